// *** inc/rtct_regs.svh ***
`ifndef RTCT_REGS_SVH
`define RTCT_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RTCT_OFS_SECONDS 8'h00
`define RTCT_OFS_MINUTES 8'h01
`define RTCT_OFS_HOURS 8'h02
`define RTCT_OFS_WEEKDAY 8'h03
`define RTCT_OFS_CTRL_ONE 8'h04
`define RTCT_OFS_CTRL_TWO 8'h05

// ****************************************************************
// Field positions
// ****************************************************************
`define RTCT_BIT_BUSY 7
`define RTCT_BIT_HOURS_RSVD 6
`define RTCT_BIT_RUN 7
`define RTCT_BIT_H24 6
`define RTCT_BIT_PM 5
`define RTCT_BIT_SOFT_RST 4
`define RTCT_BIT_FREE_RUN 0
`define RTCT_BIT_EV_SEC 1
`define RTCT_BIT_EV_MIN 2
`define RTCT_BIT_EV_HOUR 3
`define RTCT_BIT_EV_DAY 4
`define RTCT_BIT_EV_WEEK 5

// ****************************************************************
// Reset values and count limits
// ****************************************************************
`define RTCT_RST_COUNT 8'h00
`define RTCT_RST_CTRL 8'h00
`define RTCT_RD_UNMAPPED 8'h00
`define RTCT_MAX_SEC 8'h59
`define RTCT_MAX_MIN 8'h59
`define RTCT_MAX_HOUR_12 8'h11
`define RTCT_MAX_HOUR_24 8'h23
`define RTCT_MAX_WEEKDAY 3'h6
`define RTCT_MAX_ONES 4'h9

// ****************************************************************
// Timing
// ****************************************************************
`define RTCT_CLK_PERIOD_NS 20
`define RTCT_TICK_PERIOD_NS 1000000000
`define RTCT_TICK_CYCLES (`RTCT_TICK_PERIOD_NS / `RTCT_CLK_PERIOD_NS)

`endif

// *** inc/rtct_pkg.sv ***
// ****************************************************************
// Types shared by the time counter files
// ****************************************************************
package rtct_pkg;

    // Update sequence around each one-second tick
    typedef enum logic [1:0] {
        RTCT_IDLE,
        RTCT_BUSY,
        RTCT_APPLY
    } rtct_upd_state_t;

    typedef logic [7:0] rtct_byte_t;

endpackage

// *** verilog/rtct_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// One-second enable and divided clock output
// ****************************************************************
module rtct_prescaler
    import rtct_pkg::*;
#(
    parameter int CYCLES_PER_SEC = 50000000
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic run_in,
    output logic tick_out,
    output logic divided_clock_out
);

    localparam int CW = $clog2(CYCLES_PER_SEC);
    localparam logic [CW-1:0] LAST = CW'(CYCLES_PER_SEC - 1);
    localparam logic [CW-1:0] HALF = CW'(CYCLES_PER_SEC / 2 - 1);

    // The update sequence needs three cycles between ticks
    generate
        if (CYCLES_PER_SEC < 4) begin : g_bad
            $error("rtct_prescaler: CYCLES_PER_SEC must be at least 4");
        end
    endgenerate

    logic [CW-1:0] cnt_q;

    // Divider restarts while stopped so a start gives a full first second
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
        end else if (!run_in || cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    // One-cycle enable at the end of every second
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= run_in && cnt_q == LAST;
        end
    end

    // Square wave at the tick rate, low while stopped
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            divided_clock_out <= 1'b0;
        end else if (!run_in) begin
            divided_clock_out <= 1'b0;
        end else if (cnt_q == HALF || cnt_q == LAST) begin
            divided_clock_out <= ~divided_clock_out; // RL15
        end
    end

endmodule

`default_nettype wire

// *** verilog/rtct_time_counter.sv ***
// What this block does
// (RL1) Seconds register holds BCD seconds from 00 to 59.
// (RL2) Bit 7 of seconds, minutes, hours reads 1 while counters update.
// (RL3) Software trusts time values only when that busy bit reads 0.
// (RL4) Seconds ones digit counts 0 to 9 per second, carrying to tens.
// (RL5) Seconds tens digit counts 0 to 5, sixty values in all.
// (RL6) Free running mode turns seconds into an 8-bit binary counter.
// (RL7) Minutes count BCD 00 to 59 on the seconds carry.
// (RL8) Minutes ones digit counts 0 to 9, carrying to tens.
// (RL9) Minutes tens digit counts 0 to 5.
// (RL10) Hours count BCD once per hour on the minutes carry.
// (RL11) Hours span 00 to 11 in 12-hour mode, 00 to 23 in 24-hour.
// (RL12) Hours tens digit sits in bits 5:4 and counts 0 to 2.
// (RL13) Hours ones digit counts 0 to 9, carrying to tens.
// (RL14) Hours bit 6 is reserved and reads 0.
// (RL15) A divided clock drives the clock output pin.
// (RL16) Software reads and writes seconds, minutes, hours, weekday.
// (RL17) Periodic events at second, minute, hour, day, week intervals.
// (RL18) Weekday advances per day on the hours carry, holding 0 to 6.
// (RL19) Counting halts when run is 0 and proceeds when 1.
// (RL20) Format bit 1 selects 24-hour, 0 selects 12-hour counting.
// (RL21) In 12-hour mode the afternoon flag reads 1 for p.m.
// (RL22) Each counter wraps to zero at its maximum with one carry.
// (RL23) Busy stays 1 over the whole cycle the carries are applied.
//
// Added by the designer: the register offsets and the strobed register port.
`include "rtct_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rtct_time_counter
    import rtct_pkg::*;
#(
    parameter int CYCLES_PER_SEC = `RTCT_TICK_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    output logic divided_clock_out,
    output logic [4:0] periodic_event_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    rtct_byte_t seconds_count_q;
    rtct_byte_t minutes_count_q;
    rtct_byte_t hours_count_q;
    logic [2:0] weekday_count_q;
    logic run_q;
    logic h24_q;
    logic afternoon_flag_q;
    logic soft_rst_q;
    logic free_run_q;
    logic [4:0] event_en_q;
    logic update_in_progress_q;
    rtct_upd_state_t upd_state_q;
    logic tick;
    logic apply;
    logic sec_carry;
    logic min_carry;
    logic hour_wrap;
    logic day_carry;
    logic week_carry;
    rtct_byte_t hour_max;
    logic wr_sec;
    logic wr_min;
    logic wr_hour;
    logic wr_wk;
    logic wr_c1;
    logic wr_c2;

    // BCD increment of a two-digit value; the caller handles the wrap
    function automatic rtct_byte_t bcd_inc(input rtct_byte_t v);
        rtct_byte_t r;
        if (v[3:0] == `RTCT_MAX_ONES) begin
            r = {v[7:4] + 4'h1, 4'h0}; // RL4 RL8 RL13
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // ****************************************************************
    // Second tick and clock output
    // ****************************************************************
    rtct_prescaler #(
        .CYCLES_PER_SEC(CYCLES_PER_SEC)
    ) u_prescaler (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .run_in(run_q && !soft_rst_q),
        .tick_out(tick),
        .divided_clock_out(divided_clock_out)
    );

    // ****************************************************************
    // Update sequence
    // ****************************************************************
    // Busy rises one cycle before the carries land and falls on the edge that loads the new counts,
    // so a read can never catch half of an update
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            upd_state_q <= RTCT_IDLE;
        end else begin
            case (upd_state_q)
                RTCT_IDLE: begin
                    if (tick && run_q && !soft_rst_q) begin
                        upd_state_q <= RTCT_BUSY; // RL19
                    end
                end
                RTCT_BUSY: begin
                    upd_state_q <= RTCT_APPLY;
                end
                RTCT_APPLY: begin
                    upd_state_q <= RTCT_IDLE;
                end
                default: begin
                    upd_state_q <= RTCT_IDLE;
                end
            endcase
        end
    end

    // Busy flag, held through the apply cycle
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            update_in_progress_q <= 1'b0;
        end else begin
            update_in_progress_q <= (upd_state_q == RTCT_IDLE && tick && run_q
                                     && !soft_rst_q) || upd_state_q == RTCT_BUSY; // RL23
        end
    end

    // ****************************************************************
    // Carry chain
    // ****************************************************************
    assign apply = upd_state_q == RTCT_APPLY;
    assign hour_max = h24_q ? `RTCT_MAX_HOUR_24 : `RTCT_MAX_HOUR_12; // RL11 RL20
    // Free running mode keeps the upper counters still
    assign sec_carry = apply && !free_run_q && seconds_count_q == `RTCT_MAX_SEC; // RL22
    assign min_carry = sec_carry && minutes_count_q == `RTCT_MAX_MIN;
    assign hour_wrap = min_carry && hours_count_q == hour_max;
    // A 12-hour day ends when the p.m. half wraps
    assign day_carry = hour_wrap && (h24_q || afternoon_flag_q); // RL18
    assign week_carry = day_carry && weekday_count_q == `RTCT_MAX_WEEKDAY;

    // Register write decodes
    assign wr_sec = wr_en_in && addr_in == `RTCT_OFS_SECONDS && !soft_rst_q;
    assign wr_min = wr_en_in && addr_in == `RTCT_OFS_MINUTES && !soft_rst_q;
    assign wr_hour = wr_en_in && addr_in == `RTCT_OFS_HOURS && !soft_rst_q;
    assign wr_wk = wr_en_in && addr_in == `RTCT_OFS_WEEKDAY && !soft_rst_q;
    assign wr_c1 = wr_en_in && addr_in == `RTCT_OFS_CTRL_ONE;
    assign wr_c2 = wr_en_in && addr_in == `RTCT_OFS_CTRL_TWO && !soft_rst_q;

    // ****************************************************************
    // Time counters (a software write wins over a same-cycle update, except a seconds write in free running mode)
    // ****************************************************************
    // Seconds: BCD or 8-bit binary, writes ignored in free running mode
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seconds_count_q <= `RTCT_RST_COUNT;
        end else if (soft_rst_q) begin
            seconds_count_q <= `RTCT_RST_COUNT;
        end else if (wr_sec && !free_run_q) begin
            seconds_count_q <= {1'b0, wr_data_in[6:0]}; // RL16
        end else if (apply && free_run_q) begin
            seconds_count_q <= seconds_count_q + 8'h01; // RL6
        end else if (sec_carry) begin
            seconds_count_q <= `RTCT_RST_COUNT; // RL1 RL5 RL22
        end else if (apply) begin
            seconds_count_q <= bcd_inc(seconds_count_q); // RL4
        end
    end

    // Minutes
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            minutes_count_q <= `RTCT_RST_COUNT;
        end else if (soft_rst_q) begin
            minutes_count_q <= `RTCT_RST_COUNT;
        end else if (wr_min) begin
            minutes_count_q <= {1'b0, wr_data_in[6:0]}; // RL16
        end else if (min_carry) begin
            minutes_count_q <= `RTCT_RST_COUNT; // RL9 RL22
        end else if (sec_carry) begin
            minutes_count_q <= bcd_inc(minutes_count_q); // RL7 RL8
        end
    end

    // Hours: only bits 5:0 are stored
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hours_count_q <= `RTCT_RST_COUNT;
        end else if (soft_rst_q) begin
            hours_count_q <= `RTCT_RST_COUNT;
        end else if (wr_hour) begin
            hours_count_q <= {2'b00, wr_data_in[5:0]}; // RL16 RL12
        end else if (hour_wrap) begin
            hours_count_q <= `RTCT_RST_COUNT; // RL11 RL22
        end else if (min_carry) begin
            hours_count_q <= bcd_inc(hours_count_q); // RL10 RL13
        end
    end

    // Weekday: code 7 is stored if written but is not a legal setting
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            weekday_count_q <= 3'h0;
        end else if (soft_rst_q) begin
            weekday_count_q <= 3'h0;
        end else if (wr_wk) begin
            weekday_count_q <= wr_data_in[2:0]; // RL16
        end else if (week_carry) begin
            weekday_count_q <= 3'h0; // RL22
        end else if (day_carry) begin
            weekday_count_q <= weekday_count_q + 3'h1; // RL18
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Soft reset bit stays as written; it holds everything else cleared
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            soft_rst_q <= 1'b0;
        end else if (wr_c1) begin
            soft_rst_q <= wr_data_in[`RTCT_BIT_SOFT_RST];
        end
    end

    // Run and hour format
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_q <= 1'b0;
            h24_q <= 1'b0;
        end else if (soft_rst_q) begin
            run_q <= 1'b0;
            h24_q <= 1'b0;
        end else if (wr_c1) begin
            run_q <= wr_data_in[`RTCT_BIT_RUN]; // RL19
            h24_q <= wr_data_in[`RTCT_BIT_H24]; // RL20
        end
    end

    // Afternoon flag toggles at each 12-hour wrap
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            afternoon_flag_q <= 1'b0;
        end else if (soft_rst_q) begin
            afternoon_flag_q <= 1'b0;
        end else if (wr_c1) begin
            afternoon_flag_q <= wr_data_in[`RTCT_BIT_PM];
        end else if (hour_wrap && !h24_q) begin
            afternoon_flag_q <= ~afternoon_flag_q; // RL21
        end
    end

    // Free running select and event enables
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            free_run_q <= 1'b0;
            event_en_q <= 5'h00;
        end else if (soft_rst_q) begin
            free_run_q <= 1'b0;
            event_en_q <= 5'h00;
        end else if (wr_c2) begin
            free_run_q <= wr_data_in[`RTCT_BIT_FREE_RUN]; // RL6
            event_en_q <= wr_data_in[`RTCT_BIT_EV_WEEK:`RTCT_BIT_EV_SEC];
        end
    end

    // ****************************************************************
    // Periodic events
    // ****************************************************************
    // One-cycle pulses, one per interval; the system wires them to its
    // interrupt controller
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            periodic_event_out <= 5'h00;
        end else begin
            periodic_event_out <= event_en_q
                & {week_carry, day_carry, min_carry, sec_carry, apply}; // RL17
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Data stand for exactly the cycle after the read strobe
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_out <= `RTCT_RD_UNMAPPED;
        end else if (!rd_en_in) begin
            rd_data_out <= `RTCT_RD_UNMAPPED;
        end else begin
            case (addr_in)
                `RTCT_OFS_SECONDS: begin
                    if (free_run_q) begin
                        rd_data_out <= seconds_count_q; // RL6
                    end else begin
                        rd_data_out <= {update_in_progress_q, seconds_count_q[6:0]}; // RL2
                    end
                end
                `RTCT_OFS_MINUTES: begin
                    rd_data_out <= {update_in_progress_q, minutes_count_q[6:0]}; // RL2
                end
                `RTCT_OFS_HOURS: begin
                    rd_data_out <= {update_in_progress_q, 1'b0, hours_count_q[5:0]}; // RL2 RL14
                end
                `RTCT_OFS_WEEKDAY: begin
                    rd_data_out <= {update_in_progress_q, 4'h0, weekday_count_q};
                end
                `RTCT_OFS_CTRL_ONE: begin
                    rd_data_out <= {run_q, h24_q, afternoon_flag_q, soft_rst_q, 4'h0};
                end
                `RTCT_OFS_CTRL_TWO: begin
                    rd_data_out <= {2'b00, event_en_q, free_run_q};
                end
                default: begin
                    rd_data_out <= `RTCT_RD_UNMAPPED;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// *** verif/rtct_time_counter_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtct_regs.svh"

module rtct_time_counter_properties
    import rtct_pkg::*;
#(
    parameter int CYCLES_PER_SEC = 16
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_data_out,
    input wire logic divided_clock_out,
    input wire logic [4:0] periodic_event_out
);
    // ****************************************************************
    // Helper state
    // ****************************************************************
    // Free-run mode seen from writes; seconds loses its BCD form there
    logic free_run_q;

    // Only ever errs towards skipping the seconds check, never towards a false alarm
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            free_run_q <= 1'b0;
        end else if (wr_en_in && addr_in == `RTCT_OFS_CTRL_TWO) begin
            free_run_q <= wr_data_in[`RTCT_BIT_FREE_RUN];
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    // ****************************************************************
    // Properties
    // ****************************************************************
    a_read_idle_zero: assert property (
        !rd_en_in |=> rd_data_out == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_reads_zero: assert property (
        rd_en_in && addr_in > `RTCT_OFS_CTRL_TWO |=> rd_data_out == 8'h00)
        else $error("unmapped read returned data");
    a_hours_rsvd_zero: assert property (
        rd_en_in && addr_in == `RTCT_OFS_HOURS |=> !rd_data_out[`RTCT_BIT_HOURS_RSVD])
        else $error("hours reserved bit read as one");
    a_hours_digits_bcd: assert property (
        rd_en_in && addr_in == `RTCT_OFS_HOURS
        |=> rd_data_out[5:4] <= 2'h2 && rd_data_out[3:0] <= 4'h9)
        else $error("hours digits out of range");
    a_minutes_digits_bcd: assert property (
        rd_en_in && addr_in == `RTCT_OFS_MINUTES
        |=> rd_data_out[6:4] <= 3'h5 && rd_data_out[3:0] <= 4'h9)
        else $error("minutes digits out of range");
    a_seconds_digits_bcd: assert property (
        rd_en_in && addr_in == `RTCT_OFS_SECONDS && !free_run_q
        |=> rd_data_out[6:4] <= 3'h5 && rd_data_out[3:0] <= 4'h9)
        else $error("seconds digits out of range");
    a_weekday_range: assert property (
        rd_en_in && addr_in == `RTCT_OFS_WEEKDAY
        |=> rd_data_out[6:3] == 4'h0 && rd_data_out[2:0] <= 3'h6)
        else $error("weekday out of range");
    a_sec_event_single: assert property (
        periodic_event_out[0] |=> (!periodic_event_out[0]) [*8])
        else $error("second event longer than a pulse or too frequent");
    a_min_event_single: assert property (
        periodic_event_out[1] |=> (!periodic_event_out[1]) [*8])
        else $error("minute carry repeated");
    a_divclk_spacing: assert property (
        $rose(divided_clock_out) |=> (!$rose(divided_clock_out)) [*7])
        else $error("divided clock rises too close together");
endmodule

bind rtct_time_counter rtct_time_counter_properties #(
    .CYCLES_PER_SEC(CYCLES_PER_SEC)
) rtct_time_counter_properties_inst (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .divided_clock_out(divided_clock_out),
    .periodic_event_out(periodic_event_out)
);

`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtct_regs.svh"

module testbench
    import rtct_pkg::*;
;
    // ****************************************************************
    // Signals and design
    // ****************************************************************
    localparam int CPS = 16; // Short second keeps every rollover case brief

    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    rtct_byte_t addr_in = 8'h00;
    rtct_byte_t wr_data_in = 8'h00;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    rtct_byte_t rd_data_out;
    logic divided_clock_out;
    logic [4:0] periodic_event_out;
    logic [4:0] ev_seen = 5'h00;
    logic ev_clr = 1'b0;
    int mismatches = 0;
    int total_checks = 0;

    rtct_time_counter #(
        .CYCLES_PER_SEC(CPS)
    ) rtct_time_counter_inst (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .addr_in(addr_in),
        .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out),
        .divided_clock_out(divided_clock_out),
        .periodic_event_out(periodic_event_out)
    );

    // 50 MHz system clock
    always #10 clk_sys_in = ~clk_sys_in;

    // Pulses last one cycle, so they are gathered rather than sampled late;
    // the clear comes through this process so the collector has one driver
    always @(posedge clk_sys_in) begin
        ev_seen <= ev_clr ? 5'h00 : (ev_seen | periodic_event_out);
    end

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic wr(input rtct_byte_t a, input rtct_byte_t d);
        @(posedge clk_sys_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge clk_sys_in);
        wr_en_in <= 1'b0;
    endtask

    // Data stand only in the cycle after the read edge
    task automatic rd(input rtct_byte_t a, output rtct_byte_t d);
        @(posedge clk_sys_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_en_in <= 1'b0;
        #1;
        d = rd_data_out;
    endtask

    task automatic chk(input string what, input rtct_byte_t exp, input rtct_byte_t got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input rtct_byte_t a, input rtct_byte_t exp, input string what);
        rtct_byte_t d;
        rd(a, d);
        chk(what, exp, d);
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One tick from a preset time; packed as s m h w c1 c2, then expected s m h w c1 events
    task automatic tick_case(input logic [95:0] v);
        rtct_byte_t d;
        int n;
        wr(`RTCT_OFS_CTRL_ONE, 8'h00);
        wr(`RTCT_OFS_CTRL_TWO, 8'h3E);
        wr(`RTCT_OFS_SECONDS, v[95:88]);
        wr(`RTCT_OFS_MINUTES, v[87:80]);
        wr(`RTCT_OFS_HOURS, v[79:72]);
        wr(`RTCT_OFS_WEEKDAY, v[71:64]);
        wr(`RTCT_OFS_CTRL_TWO, v[55:48]);
        ev_clr <= 1'b1;
        wr(`RTCT_OFS_CTRL_ONE, v[63:56]);
        ev_clr <= 1'b0;
        n = 0;
        d = 8'h00;
        // A read every two cycles cannot miss the two-cycle busy window
        while (d[7] !== 1'b1 && n < 30) begin
            rd(`RTCT_OFS_MINUTES, d);
            n++;
        end
        chk("busy during update", 8'h80, d & 8'h80);
        while (d[7] !== 1'b0 && n < 60) begin
            rd(`RTCT_OFS_MINUTES, d);
            n++;
        end
        chk("busy after update", 8'h00, d & 8'h80);
        rd_chk(`RTCT_OFS_CTRL_ONE, v[15:8], "control after tick");
        // Stop well before the next tick so the reads see one update only
        wr(`RTCT_OFS_CTRL_ONE, v[15:8] & 8'h7F);
        repeat (40) @(posedge clk_sys_in);
        chk("divided clock stopped", 8'h00, {7'h00, divided_clock_out});
        rd_chk(`RTCT_OFS_SECONDS, v[47:40], "seconds");
        rd_chk(`RTCT_OFS_MINUTES, v[39:32], "minutes");
        rd_chk(`RTCT_OFS_HOURS, v[31:24], "hours");
        rd_chk(`RTCT_OFS_WEEKDAY, v[23:16], "weekday");
        chk("periodic events", v[7:0], {3'h0, ev_seen});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int i;
        int n;
        logic prev;
        repeat (20) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd_chk(i[7:0], 8'h00, "reset value");
        end
        wr(8'hFF, 8'h5A);
        rd_chk(8'hFF, 8'h00, "unmapped");
        wr(`RTCT_OFS_SECONDS, 8'h42);
        wr(`RTCT_OFS_MINUTES, 8'hA5);
        wr(`RTCT_OFS_HOURS, 8'h45);
        wr(`RTCT_OFS_WEEKDAY, 8'h0B);
        rd_chk(`RTCT_OFS_SECONDS, 8'h42, "seconds write");
        rd_chk(`RTCT_OFS_MINUTES, 8'h25, "minutes write");
        rd_chk(`RTCT_OFS_HOURS, 8'h05, "hours write");
        rd_chk(`RTCT_OFS_WEEKDAY, 8'h03, "weekday write");
        // Rises of a running divided clock counted over four periods
        wr(`RTCT_OFS_CTRL_ONE, 8'hC0);
        repeat (20) @(posedge clk_sys_in);
        n = 0;
        prev = divided_clock_out;
        repeat (4 * CPS) begin
            @(posedge clk_sys_in);
            #1;
            if (divided_clock_out === 1'b1 && prev === 1'b0) begin
                n++;
            end
            prev = divided_clock_out;
        end
        chk("divided clock rises", 8'h04, n[7:0]);
        tick_case(96'h09_00_00_00_C0_3E_10_00_00_00_C0_01);
        tick_case(96'h59_09_00_00_C0_3E_00_10_00_00_C0_03);
        tick_case(96'h59_59_09_00_C0_3E_00_00_10_00_C0_07);
        tick_case(96'h59_59_23_06_C0_3E_00_00_00_00_C0_1F);
        tick_case(96'h59_59_11_02_80_3E_00_00_00_02_A0_07);
        tick_case(96'h59_59_11_02_A0_3E_00_00_00_03_80_0F);
        tick_case(96'h59_59_23_06_C0_02_00_00_00_00_C0_01);
        tick_case(96'h59_59_05_01_C0_3F_5A_59_05_01_C0_01);
        // Soft reset clears the counters and controls and refuses time writes
        wr(`RTCT_OFS_CTRL_ONE, 8'hD0);
        wr(`RTCT_OFS_SECONDS, 8'h33);
        rd_chk(`RTCT_OFS_SECONDS, 8'h00, "soft reset seconds");
        rd_chk(`RTCT_OFS_MINUTES, 8'h00, "soft reset minutes");
        rd_chk(`RTCT_OFS_CTRL_ONE, 8'h10, "soft reset control");
        rd_chk(`RTCT_OFS_CTRL_TWO, 8'h00, "soft reset control two");
        finish_test();
    end

    // Whole run needs under 900 cycles; the limit leaves a wide margin
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        mismatches++;
        finish_test();
    end
endmodule

`default_nettype wire
